/* File: core/ead_pkg.sv */
// Package holding field layouts, encodings and widths for the effective address decoder.
package ead_pkg;

    // Field positions inside the addressing-form byte.
    localparam int FORM_HI = 7;
    localparam int FORM_LO = 6;
    localparam int REGF_HI = 5;
    localparam int REGF_LO = 3;
    localparam int LOC_HI = 2;
    localparam int LOC_LO = 0;

    // Field positions inside the scale-index-base byte.
    localparam int SCALE_HI = 7;
    localparam int SCALE_LO = 6;
    localparam int INDEX_HI = 5;
    localparam int INDEX_LO = 3;
    localparam int BASE_HI = 2;
    localparam int BASE_LO = 0;

    // Form field codes.
    localparam logic [1:0] FORM_NODISP = 2'h0;
    localparam logic [1:0] FORM_DISP8 = 2'h1;
    localparam logic [1:0] FORM_DISPW = 2'h2;
    localparam logic [1:0] FORM_REG = 2'h3;

    // Register numbers in the general register file.
    localparam logic [2:0] REG_AX = 3'h0;
    localparam logic [2:0] REG_BX = 3'h3;
    localparam logic [2:0] REG_SP = 3'h4;
    localparam logic [2:0] REG_BP = 3'h5;
    localparam logic [2:0] REG_SI = 3'h6;
    localparam logic [2:0] REG_DI = 3'h7;

    // Special locator codes.
    localparam logic [2:0] LOC16_DIRECT = 3'h6;
    localparam logic [2:0] LOC32_SIB = 3'h4;
    localparam logic [2:0] LOC32_DIRECT = 3'h5;
    localparam logic [2:0] INDEX_NONE = 3'h4;
    localparam logic [1:0] SCALE_ONE = 2'h0;

    // Prefix byte that flips the address size.
    localparam logic [7:0] ADDR_SIZE_PREFIX = 8'h67;

    // Displacement size and default segment encodings.
    typedef enum logic [1:0] {
        EAD_DISP_NONE = 2'h0,
        EAD_DISP_8BIT = 2'h1,
        EAD_DISP_16BIT = 2'h2,
        EAD_DISP_32BIT = 2'h3
    } ead_disp_type;

    typedef enum logic [1:0] {
        EAD_SEG_DATA = 2'h0,
        EAD_SEG_STACK = 2'h1
    } ead_seg_type;

    // Register operand width encodings.
    typedef enum logic [1:0] {
        EAD_W8 = 2'h0,
        EAD_W16 = 2'h1,
        EAD_W32 = 2'h2
    } ead_width_type;

    localparam int OFFSET_W = 32;
    localparam logic [31:0] WRAP16_MASK = 32'h0000FFFF;

endpackage : ead_pkg

/* File: core/ead_offset_adder.sv */
// Offset adder: base plus scaled index plus sign-extended displacement.
`timescale 1ns/1ps

module ead_offset_adder #(
    parameter int WIDTH = 32
) (
    // Address components.
    input wire logic [WIDTH-1:0] base_val_i,
    input wire logic base_en_i,
    input wire logic [WIDTH-1:0] index_val_i,
    input wire logic index_en_i,
    input wire logic [1:0] scale_i,
    input wire logic [31:0] disp_i,
    input wire ead_pkg::ead_disp_type disp_kind_i,
    input wire logic addr32_i,
    // Result.
    output logic [WIDTH-1:0] offset_o
);

    logic [WIDTH-1:0] base_term;
    logic [WIDTH-1:0] index_term;
    logic [31:0] disp_ext;
    logic [WIDTH-1:0] sum;

    // Scaling is a shift; x1, x2, x4, x8 follow the two scale bits.
    assign base_term = base_en_i ? base_val_i : '0;
    assign index_term = index_en_i ? (index_val_i << scale_i) : '0; // [RULE7]

    // Byte displacement is sign extended; a word displacement is too in 16-bit mode.
    assign disp_ext = (disp_kind_i == ead_pkg::EAD_DISP_8BIT) ? {{24{disp_i[7]}}, disp_i[7:0]} :
                      (disp_kind_i == ead_pkg::EAD_DISP_16BIT) ? {{16{disp_i[15]}}, disp_i[15:0]} :
                      (disp_kind_i == ead_pkg::EAD_DISP_32BIT) ? disp_i : 32'h00000000; // [RULE2]

    assign sum = base_term + index_term + disp_ext[WIDTH-1:0]; // [RULE7]

    // Sixteen-bit addressing wraps modulo 65536 rather than carrying upward.
    assign offset_o = addr32_i ? sum : (sum & ead_pkg::WRAP16_MASK[WIDTH-1:0]); // [RULE13]

endmodule : ead_offset_adder

/* File: core/ead_decoder.sv */
// Effective address decoder: addressing bytes to base, index, scale, displacement and segment.
`timescale 1ns/1ps

// Summary of operation
// RULE1 - Form 00 in 16-bit mode gives BX+SI, BX+DI, BP+SI, BP+DI, SI, DI, disp16 alone or BX.
// RULE2 - In 16-bit addressing forms 01 and 10 add disp8 or disp16 and locator 110 means BP.
// RULE3 - In 32-bit mode locator 100 adds a scale-index-base byte and 00 101 is a bare disp32.
// RULE4 - Without that byte the 32-bit locator names the base, with disp8 or disp32 by form.
// RULE5 - Form 11 selects a register operand, byte registers when the width bit is 0.
// RULE6 - Scale-index-base base 100 is ESP, and 101 is disp32 alone in form 00, else EBP.
// RULE7 - The index value is multiplied by one, two, four or eight and added to the offset.
// RULE8 - Instructions with an implied addressing form have no addressing byte decoded.
// RULE9 - Memory forms use the data segment except BP-based, ESP-based and EBP-based forms use stack.
// RULE10 - Index code 100 means no index and a nonzero scale then flags an undefined address.
// RULE11 - The width bit selects byte operands when 0 and the current operand size when 1.
// RULE12 - The address-size prefix inverts the default address size for the next instruction only.
// RULE13 - Sixteen-bit offsets wrap modulo 65536.
module ead_decoder #(
    parameter int WIDTH = ead_pkg::OFFSET_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic reset_i,
    // Instruction fields from the opcode decoder.
    input wire logic valid_i,
    input wire logic has_form_byte_i,
    input wire logic [7:0] form_byte_i,
    input wire logic [7:0] sib_byte_i,
    input wire logic default_addr32_i,
    input wire logic addr_prefix_i,
    input wire logic oper32_i,
    input wire logic width_bit_i,
    input wire logic [31:0] disp_i,
    // Register values from the register file.
    input wire logic [WIDTH-1:0] base_val_i,
    input wire logic [WIDTH-1:0] index_val_i,
    // Decoded recipe.
    output logic valid_o,
    output logic mem_o,
    output logic addr32_o,
    output logic needs_sib_o,
    output logic base_en_o,
    output logic [2:0] base_reg_o,
    output logic index_en_o,
    output logic [2:0] index_reg_o,
    output logic [1:0] scale_o,
    output ead_pkg::ead_disp_type disp_kind_o,
    output ead_pkg::ead_seg_type seg_o,
    output logic [2:0] reg_sel_o,
    output ead_pkg::ead_width_type reg_width_o,
    output logic undefined_o,
    output logic [WIDTH-1:0] offset_o
);

    logic addr32;
    logic [1:0] form;
    logic [2:0] loc;
    logic [1:0] scale;
    logic [2:0] index;
    logic [2:0] base;
    logic decode_on;
    logic is_reg;
    logic sib_used;
    logic is_mem;
    logic base_en;
    logic [2:0] base_reg;
    logic index_en;
    logic [2:0] index_reg;
    logic [1:0] scale_eff;
    logic undef_ea;
    ead_pkg::ead_disp_type disp_kind;
    ead_pkg::ead_seg_type seg;
    ead_pkg::ead_width_type reg_width;
    logic [WIDTH-1:0] offset;

    // The prefix flips the default only for this instruction; no state is kept.
    assign addr32 = default_addr32_i ^ addr_prefix_i; // [RULE12]

    // Field extraction.
    assign form = form_byte_i[ead_pkg::FORM_HI:ead_pkg::FORM_LO];
    assign loc = form_byte_i[ead_pkg::LOC_HI:ead_pkg::LOC_LO];
    assign scale = sib_byte_i[ead_pkg::SCALE_HI:ead_pkg::SCALE_LO];
    assign index = sib_byte_i[ead_pkg::INDEX_HI:ead_pkg::INDEX_LO];
    assign base = sib_byte_i[ead_pkg::BASE_HI:ead_pkg::BASE_LO];

    // Implied-form instructions never decode the byte, so the byte lines are ignored.
    assign decode_on = valid_i && has_form_byte_i; // [RULE8]
    assign is_reg = decode_on && (form == ead_pkg::FORM_REG); // [RULE5]
    assign is_mem = decode_on && (form != ead_pkg::FORM_REG);
    assign sib_used = is_mem && addr32 && (loc == ead_pkg::LOC32_SIB); // [RULE3]

    // Register operand width from the width bit and the operand size.
    assign reg_width = !width_bit_i ? ead_pkg::EAD_W8 :
                       (oper32_i ? ead_pkg::EAD_W32 : ead_pkg::EAD_W16); // [RULE11]

    // Memory recipe decode; one process covers both address-size tables.
    always_comb
    begin
        base_en = 1'b0;
        base_reg = ead_pkg::REG_AX;
        index_en = 1'b0;
        index_reg = ead_pkg::REG_AX;
        scale_eff = ead_pkg::SCALE_ONE;
        disp_kind = ead_pkg::EAD_DISP_NONE;
        seg = ead_pkg::EAD_SEG_DATA; // [RULE9]
        undef_ea = 1'b0;
        if (is_mem && !addr32)
        begin
            // Sixteen-bit table: low locators pair BX/BP with SI/DI.
            unique case (loc)
                3'h0, 3'h1, 3'h2, 3'h3:
                begin
                    base_en = 1'b1;
                    base_reg = loc[1] ? ead_pkg::REG_BP : ead_pkg::REG_BX; // [RULE1]
                    index_en = 1'b1;
                    index_reg = loc[0] ? ead_pkg::REG_DI : ead_pkg::REG_SI;
                    seg = loc[1] ? ead_pkg::EAD_SEG_STACK : ead_pkg::EAD_SEG_DATA; // [RULE9]
                end
                3'h4, 3'h5:
                begin
                    base_en = 1'b1;
                    base_reg = loc[0] ? ead_pkg::REG_DI : ead_pkg::REG_SI; // [RULE1]
                end
                3'h6:
                begin
                    if (form != ead_pkg::FORM_NODISP)
                    begin
                        base_en = 1'b1;
                        base_reg = ead_pkg::REG_BP; // [RULE2]
                        seg = ead_pkg::EAD_SEG_STACK; // [RULE9]
                    end
                end
                3'h7:
                begin
                    base_en = 1'b1;
                    base_reg = ead_pkg::REG_BX; // [RULE1]
                end
            endcase
            if (form == ead_pkg::FORM_DISP8)
                disp_kind = ead_pkg::EAD_DISP_8BIT; // [RULE2]
            else if (form == ead_pkg::FORM_DISPW || loc == ead_pkg::LOC16_DIRECT)
                disp_kind = ead_pkg::EAD_DISP_16BIT; // [RULE1]
        end
        else if (is_mem)
        begin
            // Thirty-two-bit table, with or without the scale-index-base byte.
            if (sib_used)
            begin
                index_en = (index != ead_pkg::INDEX_NONE); // [RULE10]
                index_reg = index;
                scale_eff = scale; // [RULE7]
                undef_ea = (index == ead_pkg::INDEX_NONE)
                    && (scale != ead_pkg::SCALE_ONE); // [RULE10]
                base_en = !(form == ead_pkg::FORM_NODISP
                    && base == ead_pkg::LOC32_DIRECT); // [RULE6]
                base_reg = base;
                if (base == ead_pkg::REG_SP || (base == ead_pkg::REG_BP && base_en))
                    seg = ead_pkg::EAD_SEG_STACK; // [RULE6]
                if (!base_en)
                    disp_kind = ead_pkg::EAD_DISP_32BIT; // [RULE6]
            end
            else
            begin
                base_en = !(form == ead_pkg::FORM_NODISP
                    && loc == ead_pkg::LOC32_DIRECT); // [RULE3]
                base_reg = loc; // [RULE4]
                if (base_en && loc == ead_pkg::REG_BP)
                    seg = ead_pkg::EAD_SEG_STACK; // [RULE4]
                if (!base_en)
                    disp_kind = ead_pkg::EAD_DISP_32BIT; // [RULE3]
            end
            if (form == ead_pkg::FORM_DISP8)
                disp_kind = ead_pkg::EAD_DISP_8BIT; // [RULE4]
            else if (form == ead_pkg::FORM_DISPW)
                disp_kind = ead_pkg::EAD_DISP_32BIT; // [RULE4]
        end
    end

    // Offset arithmetic uses the register values that the datapath looked up.
    ead_offset_adder #(
        .WIDTH(WIDTH)
    ) u_adder (
        .base_val_i(base_val_i),
        .base_en_i(base_en),
        .index_val_i(index_val_i),
        .index_en_i(index_en),
        .scale_i(scale_eff),
        .disp_i(disp_i),
        .disp_kind_i(disp_kind),
        .addr32_i(addr32),
        .offset_o(offset)
    );

    // Output stage: every result is registered so the datapath sees one clean edge.
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            valid_o <= 1'b0;
            mem_o <= 1'b0;
            addr32_o <= 1'b0;
            needs_sib_o <= 1'b0;
            base_en_o <= 1'b0;
            base_reg_o <= ead_pkg::REG_AX;
            index_en_o <= 1'b0;
            index_reg_o <= ead_pkg::REG_AX;
            scale_o <= ead_pkg::SCALE_ONE;
            disp_kind_o <= ead_pkg::EAD_DISP_NONE;
            seg_o <= ead_pkg::EAD_SEG_DATA;
            reg_sel_o <= ead_pkg::REG_AX;
            reg_width_o <= ead_pkg::EAD_W8;
            undefined_o <= 1'b0;
            offset_o <= '0;
        end
        else
        begin
            valid_o <= valid_i;
            mem_o <= is_mem;
            addr32_o <= addr32;
            needs_sib_o <= sib_used;
            base_en_o <= base_en;
            base_reg_o <= base_reg;
            index_en_o <= index_en;
            index_reg_o <= index_reg;
            scale_o <= scale_eff;
            disp_kind_o <= disp_kind;
            seg_o <= seg;
            reg_sel_o <= is_reg ? loc : ead_pkg::REG_AX; // [RULE5]
            reg_width_o <= reg_width;
            undefined_o <= undef_ea;
            offset_o <= offset;
        end
    end

endmodule : ead_decoder

/* File: tb/ead_decoder_assertions.sv */
// Checker tying the decoded recipe fields, except valid, index, scale and offset, to the instruction bytes one cycle earlier.
`timescale 1ns/1ps
module ead_chk (
    // Clock, reset and instruction fields.
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic valid_i,
    input wire logic has_form_byte_i,
    input wire logic [7:0] form_byte_i,
    input wire logic [7:0] sib_byte_i,
    input wire logic default_addr32_i,
    input wire logic addr_prefix_i,
    input wire logic width_bit_i,
    // Decoded recipe.
    input wire logic mem_o,
    input wire logic addr32_o,
    input wire logic needs_sib_o,
    input wire logic base_en_o,
    input wire logic [2:0] base_reg_o,
    input wire logic [2:0] reg_sel_o,
    input wire ead_pkg::ead_disp_type disp_kind_o,
    input wire ead_pkg::ead_seg_type seg_o,
    input wire ead_pkg::ead_width_type reg_width_o,
    input wire logic undefined_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);
    // The form byte only counts when the request is valid and carries one.
    wire logic go = valid_i && has_form_byte_i;
    wire logic a32 = default_addr32_i ^ addr_prefix_i;
    wire logic [1:0] form = form_byte_i[7:6];
    wire logic [2:0] loc = form_byte_i[2:0];
    wire logic sib = go && a32 && form != 2'h3 && loc == 3'h4;
    wire logic scl_nz = sib_byte_i[7:6] != 2'h0;
    refuse_form_a: assert property (!go |=> !mem_o && !base_en_o && reg_sel_o == 3'h0)
        else $error("refused request still decoded");
    size_flip_a: assert property (valid_i |=> addr32_o == $past(a32))
        else $error("address size not flipped by prefix");
    direct16_a: assert property (go && !a32 && form == 2'h0 && loc == 3'h6
        |=> mem_o && !base_en_o && disp_kind_o == ead_pkg::EAD_DISP_16BIT)
        else $error("bare 16-bit displacement wrong");
    bp_stack_a: assert property (go && !a32 && form inside {2'h1, 2'h2} && loc == 3'h6
        |=> base_en_o && base_reg_o == 3'h5 && seg_o == ead_pkg::EAD_SEG_STACK)
        else $error("BP form wrong");
    sib_flag_a: assert property (go && a32 && form != 2'h3
        |=> needs_sib_o == $past(sib))
        else $error("sib flag wrong");
    bare32_a: assert property (go && a32 && form == 2'h0 && loc == 3'h5
        |=> !base_en_o && disp_kind_o == ead_pkg::EAD_DISP_32BIT
        && seg_o == ead_pkg::EAD_SEG_DATA)
        else $error("bare 32-bit displacement wrong");
    reg_mode_a: assert property (go && form == 2'h3
        |=> !mem_o && reg_sel_o == $past(loc))
        else $error("register operand wrong");
    byte_width_a: assert property (go && form == 2'h3 && !width_bit_i
        |=> reg_width_o == ead_pkg::EAD_W8)
        else $error("byte width not chosen");
    undef_idx_a: assert property (sib && sib_byte_i[5:3] == 3'h4
        |=> undefined_o == $past(scl_nz))
        else $error("undefined flag wrong");
    esp_stack_a: assert property (sib && sib_byte_i[2:0] == 3'h4
        |=> base_reg_o == 3'h4 && seg_o == ead_pkg::EAD_SEG_STACK)
        else $error("ESP base wrong");
    cover property (sib && scl_nz);
    cover property (go && form == 2'h3);
    cover property (!go);
endmodule : ead_chk
bind ead_decoder ead_chk i_ead_chk (.clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i),
    .has_form_byte_i(has_form_byte_i), .form_byte_i(form_byte_i), .sib_byte_i(sib_byte_i),
    .default_addr32_i(default_addr32_i), .addr_prefix_i(addr_prefix_i),
    .width_bit_i(width_bit_i), .mem_o(mem_o), .addr32_o(addr32_o), .needs_sib_o(needs_sib_o),
    .base_en_o(base_en_o), .base_reg_o(base_reg_o), .reg_sel_o(reg_sel_o),
    .disp_kind_o(disp_kind_o), .seg_o(seg_o), .reg_width_o(reg_width_o),
    .undefined_o(undefined_o));

/* File: tb/ead_regfile_model.sv */
// Register file model answering base and index register values.
`timescale 1ns/1ps
module ead_regfile_model (
    // Register numbers the bench expects to be read.
    input wire logic [2:0] base_num_i,
    input wire logic [2:0] index_num_i,
    // Register contents.
    output logic [31:0] base_val_o,
    output logic [31:0] index_val_o
);
    // Every nibble holds the register number, so a wrong pick shows in the offset.
    assign base_val_o = {8{1'b0, base_num_i}};
    assign index_val_o = {8{1'b0, index_num_i}};
endmodule : ead_regfile_model

/* File: tb/tb_effective_address_decoder.sv */
// Self-checking bench for the effective address decoder.
`timescale 1ns/1ps
module tb_effective_address_decoder;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic valid_i = 1'b0;
    logic has_form_byte_i = 1'b1;
    logic [7:0] form_byte_i = 8'h00;
    logic [7:0] sib_byte_i = 8'h00;
    logic default_addr32_i = 1'b0;
    logic addr_prefix_i = 1'b0;
    logic oper32_i = 1'b0;
    logic width_bit_i = 1'b0;
    logic [31:0] disp_i = 32'h0;
    logic [2:0] base_num = 3'h0;
    logic [2:0] index_num = 3'h0;
    logic [31:0] base_val, index_val, offset_o;
    logic valid_o, mem_o, addr32_o, needs_sib_o, base_en_o, index_en_o, undefined_o;
    logic [2:0] base_reg_o, index_reg_o, reg_sel_o;
    logic [1:0] scale_o;
    ead_pkg::ead_disp_type disp_kind_o;
    ead_pkg::ead_seg_type seg_o;
    ead_pkg::ead_width_type reg_width_o;
    int failures = 0;
    int n_checks = 0;
    // Core clock.
    always #5 clk_i = ~clk_i;
    ead_decoder i_ead_decoder (.clk_i(clk_i), .reset_i(reset_i), .valid_i(valid_i),
        .has_form_byte_i(has_form_byte_i), .form_byte_i(form_byte_i), .sib_byte_i(sib_byte_i),
        .default_addr32_i(default_addr32_i), .addr_prefix_i(addr_prefix_i), .oper32_i(oper32_i),
        .width_bit_i(width_bit_i), .disp_i(disp_i), .base_val_i(base_val),
        .index_val_i(index_val), .valid_o(valid_o), .mem_o(mem_o), .addr32_o(addr32_o),
        .needs_sib_o(needs_sib_o), .base_en_o(base_en_o), .base_reg_o(base_reg_o),
        .index_en_o(index_en_o), .index_reg_o(index_reg_o), .scale_o(scale_o),
        .disp_kind_o(disp_kind_o), .seg_o(seg_o), .reg_sel_o(reg_sel_o),
        .reg_width_o(reg_width_o), .undefined_o(undefined_o), .offset_o(offset_o));
    ead_regfile_model i_ead_regfile_model (.base_num_i(base_num), .index_num_i(index_num),
        .base_val_o(base_val), .index_val_o(index_val));
    // Expected register contents, worked out apart from the model.
    function automatic logic [31:0] rv(input int k);
        return {8{1'b0, k[2:0]}};
    endfunction : rv
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // Presents one instruction at a falling edge; its recipe is out one edge later.
    task automatic drive(input logic a, input logic [7:0] fb, input logic [7:0] sb,
        input logic [31:0] d, input logic [2:0] bn, input logic [2:0] xn);
        default_addr32_i = a;
        form_byte_i = fb;
        sib_byte_i = sb;
        disp_i = d;
        base_num = bn;
        index_num = xn;
        valid_i = 1'b1;
        @(negedge clk_i);
    endtask : drive
    task automatic t_refused();
        has_form_byte_i = 1'b0;
        drive(1'b0, 8'h46, 8'h00, 32'h0, 3'h5, 3'h5);
        cmp({valid_o, mem_o, base_en_o, index_en_o, reg_sel_o}, 32'h40);
        has_form_byte_i = 1'b1;
        valid_i = 1'b0;
        @(negedge clk_i);
        cmp({valid_o, mem_o}, 32'h0);
    endtask : t_refused
    // Single-register 16-bit forms get the same value on both buses, so either slot works.
    task automatic t_mode16();
        logic [2:0] bt [8] = '{3'h3, 3'h3, 3'h5, 3'h5, 3'h6, 3'h7, 3'h5, 3'h3};
        logic [2:0] it [8] = '{3'h6, 3'h7, 3'h6, 3'h7, 3'h6, 3'h7, 3'h5, 3'h3};
        logic [31:0] e;
        for (int f = 0; f < 3; f++)
            for (int l = 0; l < 8; l++)
            begin
                drive(1'b0, {f[1:0], 3'h0, l[2:0]}, 8'h00, 32'h0000_80F0, bt[l], it[l]);
                e = (l < 4) ? rv(bt[l]) + rv(it[l]) : rv(bt[l]);
                if (f == 0 && l == 6)
                    e = 32'h0000_80F0;
                else
                    e = e + ((f == 1) ? 32'hFFFF_FFF0 : (f == 2) ? 32'h0000_80F0 : 32'h0);
                cmp(offset_o, e & 32'h0000_FFFF);
                cmp(seg_o, (l == 2 || l == 3 || (l == 6 && f != 0)) ? 32'h1 : 32'h0);
                cmp({valid_o, mem_o, disp_kind_o},
                    {2'h3, (f == 0 && l == 6) ? 2'h2 : f[1:0]});
                cmp({base_en_o, base_reg_o, index_en_o, index_reg_o},
                    {l != 6 || f != 0, (l == 6 && f == 0) ? 3'h0 : bt[l],
                    l < 4, (l < 4) ? it[l] : 3'h0});
            end
    endtask : t_mode16
    task automatic t_mode32();
        logic bare;
        for (int f = 0; f < 3; f++)
            for (int l = 0; l < 8; l++)
            begin
                drive(1'b1, {f[1:0], 3'h0, l[2:0]}, 8'h00, 32'h1234_56F0, l[2:0], l[2:0]);
                bare = f == 0 && l == 5;
                if (l != 4)
                begin
                    cmp({needs_sib_o, disp_kind_o, seg_o}, {1'b0, bare ? 2'h3 : (f == 2) ? 2'h3
                        : f[1:0], (l == 5 && f != 0) ? 2'h1 : 2'h0});
                    cmp(offset_o, (bare ? 32'h0 : rv(l)) + ((f == 1) ? 32'hFFFF_FFF0 : (f == 0
                        && !bare) ? 32'h0 : 32'h1234_56F0));
                end
            end
    endtask : t_mode32
    task automatic t_sib();
        int f;
        int x;
        logic nob;
        for (int s = 0; s < 4; s++)
            for (int b = 0; b < 8; b++)
            begin
                f = (b + s) % 3;
                x = (b + s) % 8;
                nob = f == 0 && b == 5;
                drive(1'b1, {f[1:0], 6'h04}, {s[1:0], x[2:0], b[2:0]}, 32'h1234_56F0,
                    b[2:0], x[2:0]);
                cmp({base_en_o, base_reg_o, index_en_o, index_reg_o, scale_o},
                    {!nob, b[2:0], x != 4, x[2:0], s[1:0]});
                cmp({needs_sib_o, undefined_o, seg_o}, {1'b1, x == 4 && s != 0,
                    (b == 4 || (b == 5 && f != 0)) ? 2'h1 : 2'h0});
                if (!(x == 4 && s != 0))
                    cmp(offset_o, (nob ? 32'h0 : rv(b)) + ((x == 4) ? 32'h0 : rv(x) << s)
                        + ((f == 1) ? 32'hFFFF_FFF0 : (f == 2 || nob) ? 32'h1234_56F0
                        : 32'h0));
            end
    endtask : t_sib
    task automatic t_regform();
        for (int c = 0; c < 8; c++)
            for (int w = 0; w < 4; w++)
            begin
                width_bit_i = w[0];
                oper32_i = w[1];
                drive(w[1], {5'h18, c[2:0]}, 8'h00, 32'h0, 3'h0, 3'h0);
                cmp({mem_o, reg_sel_o, reg_width_o}, {1'b0, c[2:0], !w[0] ? 2'h0 : w[1]
                    ? 2'h2 : 2'h1});
            end
    endtask : t_regform
    task automatic t_prefix();
        for (int p = 0; p < 4; p++)
        begin
            addr_prefix_i = p[1];
            drive(p[0], 8'h04, 8'h00, 32'h0, 3'h6, 3'h6);
            cmp({addr32_o, needs_sib_o}, {2{p[0] ^ p[1]}});
        end
        addr_prefix_i = 1'b0;
    endtask : t_prefix
    task automatic wrap_up();
        if (failures == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // Reset for four cycles, then every scenario back to back.
    initial
    begin
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        @(negedge clk_i);
        t_refused();
        t_mode16();
        t_mode32();
        t_sib();
        t_regform();
        t_prefix();
        wrap_up();
    end
endmodule : tb_effective_address_decoder
